// ===== bwsr_top.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Bus fault register at 0x44; all three registers reset to zero.
// - Reserved bit positions always read back as zero.
// - LIN fault code in bits 6:5: none, thermal, tx stuck, line stuck.
// - CAN fault code in bits 2:1 with the same encoding.
// - Bit 0 flags CAN supply undervoltage; transmitter disabled meanwhile.
// - Undervoltage comparator armed only in normal mode with CAN mode bit 1 set.
// - Wake source register at 0x46, one latched flag per wake source.
// - In stop mode, load current above threshold sets watchdog wake flag.
// - That wake restarts the watchdog with long open window unless disabled.
// - With the watchdog stop wake enable cleared, no wake event is signalled.
// - Level register at 0x48: test pin bit 7, wake inputs bits 3 to 0.
// - In cyclic modes the level register updates only after each sampling, or in bit 3 when sync is configured.
// - Configuring the sync function stores the wake input four level.
// - Latched flags stay set until cleared by a serial command or a soft reset.
module bwsr_top
  import bwsr_pkg::*;
(
  // System clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Serial control port
  input wire logic i_sclk,
  input wire logic i_csn,
  input wire logic i_sdi,
  output logic o_sdo,
  // Device mode and configuration, same clock
  input wire logic i_mode_normal,
  input wire logic i_mode_stop,
  input wire logic [1:0] i_can_mode,
  input wire logic i_wdog_active,
  input wire logic i_wdog_stop_wake_enable,
  input wire logic i_cyclic_mode,
  input wire logic i_sample_strobe,
  input wire logic i_sync_config,
  input wire logic i_soft_reset,
  // Wake event pulses, same clock
  input wire logic i_lin_wake,
  input wire logic i_can_wake,
  input wire logic i_periodic_timer_wake,
  input wire logic [3:0] i_input_wake,
  // Analog detector and pin inputs, asynchronous
  input wire bwsr_xcvr_fault_t i_lin_fault,
  input wire bwsr_xcvr_fault_t i_can_fault,
  input wire logic i_can_supply_undervolt,
  input wire logic i_wdog_off_current_threshold,
  input wire logic i_test_pin,
  input wire logic [3:0] i_wake_input,
  // Actions
  output logic o_can_tx_disable,
  output logic o_uv_comp_enable,
  output logic o_wake_event,
  output logic o_wdog_restart_long
);

  // Reset release through two flops
  // Asserts at once but releases on a clock edge, so no flop sees a runt release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Serial clock domain
  logic [3:0] bit_cnt;
  logic [14:0] rx_shift;
  bwsr_frame_t cmd_word;
  logic cmd_tgl;
  logic resp_tgl;
  logic [7:0] resp_data;
  logic resp_meta;
  logic resp_sync;
  logic resp_seen;
  logic [7:0] resp_hold;

  // Bit counter and shifter restart with every frame, so no edge outside it matters
  always_ff @(posedge i_sclk or posedge i_csn) begin
    if (i_csn) begin
      bit_cnt <= 4'h0;
      rx_shift <= 15'h0000;
    end else begin
      bit_cnt <= bit_cnt + 4'h1;
      rx_shift <= {rx_shift[13:0], i_sdi};
    end
  end

  // Finished frame is held and flagged by a toggle; held until next frame ends
  always_ff @(posedge i_sclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_word <= '0;
      cmd_tgl <= 1'b0;
    end else if (!i_csn && bit_cnt == FRAME_LAST_BIT) begin
      cmd_word <= {rx_shift, i_sdi};
      cmd_tgl <= ~cmd_tgl;
    end
  end

  // Answer toggle synchroniser; the answer word is stable once its toggle is seen
  // Loading only in the first bits keeps the byte steady while it shifts out
  always_ff @(posedge i_sclk or negedge rst_n) begin
    if (!rst_n) begin
      resp_meta <= 1'b0;
      resp_sync <= 1'b0;
      resp_seen <= 1'b0;
      resp_hold <= 8'h00;
    end else begin
      resp_meta <= resp_tgl;
      resp_sync <= resp_meta;
      if (resp_sync != resp_seen && bit_cnt < RESP_LOAD_LIMIT) begin
        resp_seen <= resp_sync;
        resp_hold <= resp_data;
      end
    end
  end

  // Output bit changes on the falling edge so the master samples on the rising one
  wire [3:0] tx_idx = bit_cnt - DATA_FIRST_BIT;
  wire in_data = bit_cnt >= DATA_FIRST_BIT;
  wire tx_bit = in_data ? resp_hold[3'(4'h7 - tx_idx)] : 1'b0;
  always_ff @(negedge i_sclk or posedge i_csn) begin
    if (i_csn) begin
      o_sdo <= 1'b0;
    end else begin
      o_sdo <= tx_bit;
    end
  end

  // System clock domain
  // Two-flop synchronisers for every asynchronous level
  // Each fault line is a level of its own, so a one-cycle mix of old and new
  // bits only delays the reported code by a cycle
  localparam int NSYNC = 14;
  wire [NSYNC-1:0] async_in = {i_lin_fault, i_can_fault, i_can_supply_undervolt,
    i_wdog_off_current_threshold, i_test_pin, i_wake_input, cmd_tgl};
  logic [NSYNC-1:0] sync_meta;
  logic [NSYNC-1:0] sync_q;
  logic cmd_seen;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_meta <= '0;
      sync_q <= '0;
      cmd_seen <= 1'b0;
    end else begin
      sync_meta <= async_in;
      sync_q <= sync_meta;
      cmd_seen <= sync_q[0];
    end
  end

  wire bwsr_xcvr_fault_t lin_f = sync_q[13:11];
  wire bwsr_xcvr_fault_t can_f = sync_q[10:8];
  wire uv_raw = sync_q[7];
  wire load_high = sync_q[6];
  wire test_pin_level = sync_q[5];
  wire [3:0] wake_lvl = sync_q[4:1];
  wire cmd_go = sync_q[0] ^ cmd_seen;

  // Fault code from the active conditions; the line fault outranks the others
  // Once every fault has ended the latched code holds until it is cleared
  function automatic bwsr_fault_t fault_code(input bwsr_xcvr_fault_t f);
    if (f.line_stuck_timeout) begin
      fault_code = BWSR_FAULT_LINE_STUCK;
    end else if (f.tx_stuck_timeout) begin
      fault_code = BWSR_FAULT_TX_STUCK;
    end else if (f.thermal_shutdown) begin
      fault_code = BWSR_FAULT_THERMAL;
    end else begin
      fault_code = BWSR_FAULT_NONE;
    end
  endfunction : fault_code

  // Command decode; a write frame clears the addressed bus fault or wake source register
  // cmd_word crosses unsynchronised: it is only used while cmd_go is high,
  // and by then it has been still for at least two system clocks
  wire hit_bus = cmd_word.addr == ADDR_BUS_FAULT;
  wire hit_wake = cmd_word.addr == ADDR_WAKE_SRC;
  wire hit_lvl = cmd_word.addr == ADDR_WAKE_LVL;
  wire clr_bus = cmd_go && cmd_word.clear && hit_bus;
  wire clr_wake = cmd_go && cmd_word.clear && hit_wake;

  logic [7:0] bus_fault_status;
  logic [7:0] wake_source_status;
  logic [7:0] wake_input_level;
  logic stop_q;
  logic load_q;
  logic wdog_was_on;

  // Bus fault flags: event sets, command clears, event wins
  wire bwsr_fault_t lin_new = fault_code(lin_f);
  wire bwsr_fault_t can_new = fault_code(can_f);
  wire uv_arm = i_mode_normal && i_can_mode[CAN_MODE_UV_BIT];
  wire uv_set = uv_arm && uv_raw;
  wire [1:0] lin_old = clr_bus ? 2'h0 : bus_fault_status[LIN_CODE_LSB +: 2];
  wire [1:0] can_old = clr_bus ? 2'h0 : bus_fault_status[CAN_CODE_LSB +: 2];
  wire [1:0] lin_next = (lin_new != BWSR_FAULT_NONE) ? lin_new : lin_old;
  wire [1:0] can_next = (can_new != BWSR_FAULT_NONE) ? can_new : can_old;
  wire uv_next = uv_set || (!clr_bus && bus_fault_status[UV_BIT]);
  wire [7:0] next_bus_fault = {1'b0, lin_next, 2'h0, can_next, uv_next} & MASK_BUS_FAULT;

  // Load-current wake in stop mode, rising edge of the detector only
  // A load that stays high therefore wakes once, not on every cycle
  wire stop_entry = i_mode_stop && !stop_q;
  wire load_wake = i_mode_stop && load_high && !load_q;
  wire [7:0] wake_set = {load_wake, i_lin_wake, i_can_wake, i_periodic_timer_wake,
    i_input_wake};
  wire [7:0] next_wake_src = wake_set | (clr_wake ? 8'h00 : wake_source_status);

  // Levels track the pins, or only the sampling instants in cyclic modes
  // Sync config also stores bit 3 outside cyclic modes, where it changes nothing
  wire lvl_load = !i_cyclic_mode || i_sample_strobe;
  logic [7:0] next_lvl;
  always_comb begin
    next_lvl = wake_input_level;
    if (lvl_load) begin
      next_lvl[TEST_PIN_LEVEL_BIT] = test_pin_level;
      next_lvl[INPUT_LVL_LSB +: 4] = wake_lvl;
    end
    if (i_sync_config) begin
      next_lvl[INPUT4_LVL_BIT] = wake_lvl[3];
    end
    next_lvl = next_lvl & MASK_WAKE_LVL;
  end

  // Status registers; soft reset returns them to zero
  // Soft reset outranks any setting event that falls in the same cycle
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_fault_status <= RST_BUS_FAULT;
      wake_source_status <= RST_WAKE_SRC;
      wake_input_level <= RST_WAKE_LVL;
    end else if (i_soft_reset) begin
      bus_fault_status <= RST_BUS_FAULT;
      wake_source_status <= RST_WAKE_SRC;
      wake_input_level <= RST_WAKE_LVL;
    end else begin
      bus_fault_status <= next_bus_fault;
      wake_source_status <= next_wake_src;
      wake_input_level <= next_lvl;
    end
  end

  // Watchdog state at stop entry decides whether a wake restarts it
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_q <= 1'b0;
      load_q <= 1'b0;
      wdog_was_on <= 1'b0;
    end else begin
      stop_q <= i_mode_stop;
      load_q <= load_high;
      if (stop_entry) begin
        wdog_was_on <= i_wdog_active;
      end
    end
  end

  // Action outputs, all registered
  // A wake on the very cycle of stop entry uses the live watchdog state,
  // because wdog_was_on has not been captured yet
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_can_tx_disable <= 1'b0;
      o_uv_comp_enable <= 1'b0;
      o_wake_event <= 1'b0;
      o_wdog_restart_long <= 1'b0;
    end else begin
      o_can_tx_disable <= uv_set;
      o_uv_comp_enable <= uv_arm;
      o_wake_event <= load_wake && i_wdog_stop_wake_enable;
      o_wdog_restart_long <= load_wake && (stop_entry ? i_wdog_active : wdog_was_on);
    end
  end

  // Read answer for each frame; reserved bits masked, unmapped reads zero
  // Taken on the same edge as the clear, so a read returns the value before it
  wire [7:0] rd_mux = hit_bus ? (bus_fault_status & MASK_BUS_FAULT) :
    hit_wake ? (wake_source_status & MASK_WAKE_SRC) :
    hit_lvl ? (wake_input_level & MASK_WAKE_LVL) : 8'h00;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_data <= 8'h00;
      resp_tgl <= 1'b0;
    end else if (cmd_go) begin
      resp_data <= rd_mux;
      resp_tgl <= ~resp_tgl;
    end
  end

endmodule : bwsr_top

`default_nettype wire

// ===== bwsr_pkg.sv
package bwsr_pkg;

  // Register addresses on the serial control port
  localparam logic [6:0] ADDR_BUS_FAULT = 7'h44;
  localparam logic [6:0] ADDR_WAKE_SRC = 7'h46;
  localparam logic [6:0] ADDR_WAKE_LVL = 7'h48;

  // Reset values of the three status registers
  localparam logic [7:0] RST_BUS_FAULT = 8'h00;
  localparam logic [7:0] RST_WAKE_SRC = 8'h00;
  localparam logic [7:0] RST_WAKE_LVL = 8'h00;

  // Masks of the bits that read back; reserved bits read as zero
  localparam logic [7:0] MASK_BUS_FAULT = 8'h67;
  localparam logic [7:0] MASK_WAKE_SRC = 8'hff;
  localparam logic [7:0] MASK_WAKE_LVL = 8'h8f;

  // Bus fault register fields
  localparam int LIN_CODE_LSB = 5;
  localparam int CAN_CODE_LSB = 1;
  localparam int UV_BIT = 0;

  // Wake source register fields
  localparam int WDOG_WAKE_BIT = 7;
  localparam int LIN_WAKE_BIT = 6;
  localparam int CAN_WAKE_BIT = 5;
  localparam int TIMER_WAKE_BIT = 4;
  localparam int INPUT_WAKE_LSB = 0;

  // Level register fields
  localparam int TEST_PIN_LEVEL_BIT = 7;
  localparam int INPUT_LVL_LSB = 0;
  localparam int INPUT4_LVL_BIT = 3;

  // Upper bit of the CAN mode setting arms the supply comparator
  localparam int CAN_MODE_UV_BIT = 1;

  // Transceiver fault codes
  typedef enum logic [1:0] {
    BWSR_FAULT_NONE = 2'h0,
    BWSR_FAULT_THERMAL = 2'h1,
    BWSR_FAULT_TX_STUCK = 2'h2,
    BWSR_FAULT_LINE_STUCK = 2'h3
  } bwsr_fault_t;

  // Serial frame: 16 bits, MSB first
  localparam logic [3:0] FRAME_LAST_BIT = 4'hf;
  localparam logic [3:0] RESP_LOAD_LIMIT = 4'h7;
  localparam logic [3:0] DATA_FIRST_BIT = 4'h8;

  typedef struct packed {
    logic [6:0] addr;
    logic clear;
    logic [7:0] data;
  } bwsr_frame_t;

  // Fault inputs of one transceiver
  typedef struct packed {
    logic thermal_shutdown;
    logic tx_stuck_timeout;
    logic line_stuck_timeout;
  } bwsr_xcvr_fault_t;

endpackage : bwsr_pkg

// ===== bwsr_checker.sv
`timescale 1ns/1ps
`default_nettype none
module bwsr_checker
  import bwsr_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Mode inputs and the undervoltage detector
  input wire logic i_mode_normal,
  input wire logic i_mode_stop,
  input wire logic [1:0] i_can_mode,
  input wire logic i_wdog_stop_wake_enable,
  input wire logic i_can_supply_undervolt,
  // Actions
  input wire logic o_can_tx_disable,
  input wire logic o_uv_comp_enable,
  input wire logic o_wake_event,
  input wire logic o_wdog_restart_long
);
  logic [1:0] settle;
  // Reset leaves through two flops, so level checks wait a few edges
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) settle <= 2'h0;
    else if (settle != 2'h3) settle <= settle + 2'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  AST_UV_ARM: assert property (settle == 2'h3 |->
    o_uv_comp_enable == $past(i_mode_normal && i_can_mode[CAN_MODE_UV_BIT]))
    else $error("comparator enable wrong");
  AST_TX_OFF_UV: assert property (
    o_can_tx_disable |-> $past(i_can_supply_undervolt, 3))
    else $error("transmitter off without undervoltage");
  AST_TX_OFF_ARMED: assert property (
    o_can_tx_disable |-> $past(i_mode_normal && i_can_mode[CAN_MODE_UV_BIT]))
    else $error("transmitter off while comparator disarmed");
  AST_WAKE_STOP: assert property (o_wake_event |-> $past(i_mode_stop))
    else $error("wake event outside stop mode");
  AST_WAKE_EN: assert property (o_wake_event |-> $past(i_wdog_stop_wake_enable))
    else $error("wake event while disabled");
  AST_WAKE_PULSE: assert property (o_wake_event |=> $fell(o_wake_event))
    else $error("wake event longer than one cycle");
  AST_RESTART: assert property (
    o_wdog_restart_long |-> $past(i_mode_stop) ##1 !o_wdog_restart_long)
    else $error("watchdog restart pulse wrong");
  AST_RESTART_WAKE: assert property (
    o_wdog_restart_long && $past(i_wdog_stop_wake_enable) |-> o_wake_event)
    else $error("restart without wake event");
endmodule : bwsr_checker
bind bwsr_top bwsr_checker chk_u (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_mode_normal(i_mode_normal), .i_mode_stop(i_mode_stop), .i_can_mode(i_can_mode),
  .i_wdog_stop_wake_enable(i_wdog_stop_wake_enable),
  .i_can_supply_undervolt(i_can_supply_undervolt), .o_can_tx_disable(o_can_tx_disable),
  .o_uv_comp_enable(o_uv_comp_enable), .o_wake_event(o_wake_event),
  .o_wdog_restart_long(o_wdog_restart_long));
`default_nettype wire

// ===== bwsr_spi_host.sv
`timescale 1ns/1ps
`default_nettype none
// Microcontroller side of the serial control port
module bwsr_spi_host (
  // Serial lines
  output logic o_sclk,
  output logic o_csn,
  output logic o_sdi,
  input wire logic i_sdo
);
  // Serial clock rests low outside frames
  initial begin
    o_sclk = 1'b0;
    o_csn = 1'b1;
    o_sdi = 1'b0;
  end
  // One frame; returns the answer to the previous frame from bits 8..15
  task automatic xfer(input logic [6:0] a, input logic c, output logic [7:0] r);
    logic [15:0] f;
    f = {a, c, 8'h00};
    #7 o_csn = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_sdi = f[i];
      #3 o_sclk = 1'b1;
      if (i < 8) r[i] = i_sdo;
      #3 o_sclk = 1'b0;
    end
    #3 o_csn = 1'b1;
    o_sdi = ~o_sdi; // Released line never shows a stale bit
    #400;
  endtask : xfer
endmodule : bwsr_spi_host
`default_nettype wire

// ===== tb_bus_and_wake_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_bus_and_wake_status_regs;
  import bwsr_pkg::*;
  // One case: levels and pulses applied, then a register read and cleared
  typedef struct packed {
    logic [2:0] lin;
    logic [2:0] can;
    logic uv;
    logic [6:0] wk;
    logic [4:0] pins;
    logic [6:0] addr;
    logic [7:0] exp;
  } bwsr_row_t;
  localparam int NR = 11;
  bwsr_row_t rows [NR] = '{
    '{3'h4, 3'h0, 1'b0, 7'h00, 5'h00, 7'h44, 8'h20},
    '{3'h2, 3'h0, 1'b0, 7'h00, 5'h00, 7'h44, 8'h40},
    '{3'h1, 3'h0, 1'b0, 7'h00, 5'h00, 7'h44, 8'h60},
    '{3'h0, 3'h4, 1'b0, 7'h00, 5'h00, 7'h44, 8'h02},
    '{3'h0, 3'h2, 1'b0, 7'h00, 5'h00, 7'h44, 8'h04},
    '{3'h0, 3'h1, 1'b0, 7'h00, 5'h00, 7'h44, 8'h06},
    '{3'h0, 3'h0, 1'b1, 7'h00, 5'h00, 7'h44, 8'h01},
    '{3'h0, 3'h0, 1'b0, 7'h55, 5'h00, 7'h46, 8'h55},
    '{3'h0, 3'h0, 1'b0, 7'h2a, 5'h00, 7'h46, 8'h2a},
    '{3'h0, 3'h0, 1'b0, 7'h00, 5'h15, 7'h48, 8'h85},
    '{3'h0, 3'h0, 1'b0, 7'h00, 5'h0a, 7'h48, 8'h0a}};
  logic clk = 1'b0, nrst = 1'b0, sclk, csn, sdi, sdo, txdis, uven, wev, wrst;
  logic normal = 1'b1, stop = 1'b0, wd_act = 1'b0, wd_en = 1'b1, cyc_m = 1'b0;
  logic smp = 1'b0, sync = 1'b0, srst = 1'b0, linw = 1'b0, canw = 1'b0, tmw = 1'b0;
  logic uv = 1'b0, ithr = 1'b0, tpin = 1'b0;
  logic [1:0] canm = 2'h2;
  logic [3:0] inw = 4'h0, wkin = 4'h0;
  bwsr_xcvr_fault_t linf = 3'h0, canf = 3'h0;
  int mismatches = 0, check_count = 0, cyc = 0;
  bwsr_top dut_u (.i_clk(clk), .i_nrst(nrst), .i_sclk(sclk), .i_csn(csn), .i_sdi(sdi),
    .o_sdo(sdo), .i_mode_normal(normal), .i_mode_stop(stop), .i_can_mode(canm),
    .i_wdog_active(wd_act), .i_wdog_stop_wake_enable(wd_en), .i_cyclic_mode(cyc_m),
    .i_sample_strobe(smp), .i_sync_config(sync), .i_soft_reset(srst), .i_lin_wake(linw),
    .i_can_wake(canw), .i_periodic_timer_wake(tmw), .i_input_wake(inw), .i_lin_fault(linf),
    .i_can_fault(canf), .i_can_supply_undervolt(uv), .i_wdog_off_current_threshold(ithr),
    .i_test_pin(tpin), .i_wake_input(wkin), .o_can_tx_disable(txdis),
    .o_uv_comp_enable(uven), .o_wake_event(wev), .o_wdog_restart_long(wrst));
  bwsr_spi_host host_u (.o_sclk(sclk), .o_csn(csn), .o_sdi(sdi), .i_sdo(sdo));
  // Clock, and a ceiling well above the expected run of about 750 cycles
  always #25 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      end_of_test();
    end
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Frame to the register, then an unmapped frame that carries its answer back
  task rd(input logic [6:0] a, input logic c, input logic [7:0] e);
    logic [7:0] r;
    host_u.xfer(a, c, r);
    chk(r, 8'h00);
    host_u.xfer(7'h00, 1'b0, r);
    chk(r, e);
    @(negedge clk);
  endtask : rd
  // Collect both action pulses over eight cycles
  task watch(input logic [1:0] e);
    logic [1:0] s;
    s = 2'h0;
    repeat (8) begin
      @(posedge clk);
      #1 s = s | {wev, wrst};
    end
    chk({6'h00, s}, {6'h00, e});
    @(negedge clk);
  endtask : watch
  task automatic pulse(ref logic s);
    @(negedge clk) s = 1'b1;
    @(negedge clk) s = 1'b0;
  endtask : pulse
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 3; k++) rd(7'h44 + 7'(2 * k), 1'b0, 8'h00);
    $display("test reset values done");
    // Faults held then removed before the clear, so the flags must stay latched
    for (int i = 0; i < NR; i++) begin
      linf = rows[i].lin;
      canf = rows[i].can;
      uv = rows[i].uv;
      {linw, canw, tmw, inw} = rows[i].wk;
      {tpin, wkin} = rows[i].pins;
      @(negedge clk) {linw, canw, tmw, inw} = 7'h00;
      repeat (6) @(negedge clk);
      {linf, canf, uv} = 7'h00;
      repeat (6) @(negedge clk);
      rd(rows[i].addr, 1'b1, rows[i].exp);
    end
    $display("test table done");
    // Undervoltage held across clears: the setting event must win
    uv = 1'b1;
    repeat (6) @(negedge clk);
    chk({6'h00, uven, txdis}, 8'h03);
    rd(ADDR_BUS_FAULT, 1'b1, 8'h01);
    rd(ADDR_BUS_FAULT, 1'b1, 8'h01);
    uv = 1'b0;
    rd(ADDR_BUS_FAULT, 1'b1, 8'h01);
    canm = 2'h1;
    uv = 1'b1;
    repeat (6) @(negedge clk);
    chk({6'h00, uven, txdis}, 8'h00);
    uv = 1'b0;
    rd(ADDR_BUS_FAULT, 1'b1, 8'h00);
    canm = 2'h2;
    $display("test undervoltage done");
    // Load current wake with the watchdog running, then disabled and unreported
    normal = 1'b0;
    wd_act = 1'b1;
    @(negedge clk) stop = 1'b1;
    @(negedge clk) ithr = 1'b1;
    watch(2'h3);
    ithr = 1'b0;
    rd(ADDR_WAKE_SRC, 1'b1, 8'h80);
    {stop, wd_act, wd_en} = 3'h0;
    @(negedge clk) stop = 1'b1;
    @(negedge clk) ithr = 1'b1;
    watch(2'h0);
    {ithr, stop, normal, wd_en} = 4'h3;
    rd(ADDR_WAKE_SRC, 1'b1, 8'h80);
    $display("test load wake done");
    // Cyclic sampling: the level register moves only at sampling or sync
    {tpin, wkin} = 5'h00;
    repeat (4) @(negedge clk);
    cyc_m = 1'b1;
    pulse(smp);
    {tpin, wkin} = 5'h1f;
    repeat (6) @(negedge clk);
    rd(ADDR_WAKE_LVL, 1'b0, 8'h00);
    pulse(sync);
    repeat (4) @(negedge clk);
    rd(ADDR_WAKE_LVL, 1'b0, 8'h08);
    pulse(smp);
    repeat (4) @(negedge clk);
    rd(ADDR_WAKE_LVL, 1'b1, 8'h8f);
    rd(ADDR_WAKE_LVL, 1'b0, 8'h8f);
    pulse(linw);
    pulse(srst);
    rd(ADDR_WAKE_SRC, 1'b0, 8'h00);
    $display("test cyclic and soft reset done");
    end_of_test();
  end
endmodule : tb_bus_and_wake_status_regs
`default_nettype wire
